/* File: design/sdl_load_control.sv */
`default_nettype none

module sdl_load_control
    import sdl_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic                   serial_clk,
    input  wire logic                   frame_sync_n,
    input  wire logic                   serial_word_in,
    input  wire logic                   chain_select,
    input  wire logic                   latch_load_n,
    input  wire logic                   latch_zero_n,
    input  wire logic                   code_format_select,
    input  wire logic                   reset_in_n,
    input  wire logic                   supply_ok,
    output logic                        cascade_out,
    output logic                        reset_out_n,
    output logic [WORD_BITS-1:0]        dac_latch,
    output logic [NODE_BITS-1:0]        segment_selector_a,
    output logic [NODE_BITS-1:0]        segment_selector_b,
    output logic [INTERP_BITS-1:0]      interpolating_converter,
    output logic                        amp_connect_gate,
    output logic                        output_clamp_gate,
    output logic                        track_hold
);

    ////////////////////////////////////////////////////////////////////////
    // Link-side logic on the serial clock.

    sdl_word_if word_bus ();

    sdl_serial_link u_link (
        .rst            (rst),
        .serial_clk     (serial_clk),
        .frame_sync_n   (frame_sync_n),
        .serial_word_in (serial_word_in),
        .chain_select   (chain_select),
        .latch_load_n   (latch_load_n),
        .cascade_out    (cascade_out),
        .word_port      (word_bus.core)
    );

    ////////////////////////////////////////////////////////////////////////
    // Crossing into the system clock.

    // The word and mode flag are quiet whenever the core looks at them:
    // with chain select low the gating freezes the word after sixteen bits and the host keeps
    // frame sync high before strobing the load input.
    logic [WORD_BITS-1:0] word_meta_reg;
    logic [WORD_BITS-1:0] word_sync_reg;
    logic [2:0]           toggle_meta_reg;
    logic [2:0]           toggle_sync_reg;
    logic                 toggle_prev_reg;
    logic                 toggle_late_reg;
    logic [3:0]           pin_meta_reg;
    logic [3:0]           pin_sync_reg;
    logic                 load_prev_reg;

    logic                 auto_sync;
    logic                 load_sync_n;
    logic                 zero_sync_n;
    logic                 reset_in_sync_n;
    logic                 format_sync;

    always_ff @(posedge clock) begin
        if (rst) begin
            word_meta_reg <= LATCH_RESET;
            word_sync_reg <= LATCH_RESET;
        end else begin
            word_meta_reg <= word_bus.word;
            word_sync_reg <= word_meta_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            toggle_meta_reg <= 3'h0;
            toggle_sync_reg <= 3'h0;
            toggle_prev_reg <= 1'b0;
            toggle_late_reg <= 1'b0;
        end else begin
            toggle_meta_reg <= {supply_ok, word_bus.auto_mode,
                                word_bus.done_toggle};
            toggle_sync_reg <= toggle_meta_reg;
            toggle_prev_reg <= toggle_sync_reg[0];
            toggle_late_reg <= toggle_prev_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta_reg  <= 4'hF;
            pin_sync_reg  <= 4'hF;
            load_prev_reg <= 1'b1;
        end else begin
            pin_meta_reg  <= {code_format_select, reset_in_n,
                              latch_zero_n, latch_load_n};
            pin_sync_reg  <= pin_meta_reg;
            load_prev_reg <= pin_sync_reg[0];
        end
    end

    assign auto_sync       = toggle_sync_reg[1];
    assign load_sync_n     = pin_sync_reg[0];
    assign zero_sync_n     = pin_sync_reg[1];
    assign reset_in_sync_n = pin_sync_reg[2];
    assign format_sync     = pin_sync_reg[3];

    ////////////////////////////////////////////////////////////////////////
    // Update events.

    logic auto_event;
    logic strobe_event;
    logic load_event;
    logic supply_good;

    assign supply_good  = toggle_sync_reg[2];
    // The event is taken one stage late so that every word bit, which
    // was caught alongside the toggle, has surely settled in the
    // word synchroniser before the latch reads it.
    assign auto_event   = (toggle_prev_reg != toggle_late_reg) &&
                          auto_sync;
    assign strobe_event = load_prev_reg && !load_sync_n;
    assign load_event   = auto_event || strobe_event;

    ////////////////////////////////////////////////////////////////////////
    // Converter latch.

    logic [WORD_BITS-1:0] latch_reg;

    // Clear is a level and wins over any load arriving alongside it.
    always_ff @(posedge clock) begin
        if (rst) begin
            latch_reg <= LATCH_RESET;
        end else if (!zero_sync_n) begin
            latch_reg <= LATCH_ZERO;
        end else if (load_event) begin
            latch_reg <= word_sync_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Deglitch hold, only for strobed updates.

    logic hold_wire;

    sdl_hold_timer u_hold (
        .clock (clock),
        .rst   (rst),
        .start (strobe_event),
        .hold  (hold_wire)
    );

    ////////////////////////////////////////////////////////////////////////
    // Output clamp control.

    sdl_out_state_t state_reg;
    sdl_out_state_t state_next;
    logic           released;

    assign released = reset_in_sync_n && supply_good;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SDL_CLAMPED: begin
                if (released && load_event && zero_sync_n) begin
                    state_next = SDL_LIVE;
                end
            end
            SDL_LIVE: begin
                if (!released) begin
                    state_next = SDL_CLAMPED;
                end
            end
            default: begin
                state_next = SDL_CLAMPED;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= SDL_CLAMPED;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Code split for the segment and interpolation converters.

    logic [WORD_BITS-1:0]   code;
    logic [SEG_BITS-1:0]    segment;
    logic [INTERP_BITS-1:0] fine;
    logic [NODE_BITS-1:0]   node_low;
    logic [NODE_BITS-1:0]   node_high;

    // Two's complement maps to offset binary by flipping the sign bit.
    assign code      = {latch_reg[WORD_BITS-1] ^ format_sync,
                        latch_reg[WORD_BITS-2:0]};
    assign segment   = code[WORD_BITS-1 -: SEG_BITS];
    assign fine      = code[INTERP_BITS-1:0];
    assign node_low  = {1'b0, segment};
    assign node_high = node_low + 5'h01;

    logic [WORD_BITS-1:0]   latch_out_reg;
    logic [NODE_BITS-1:0]   sel_a_reg;
    logic [NODE_BITS-1:0]   sel_b_reg;
    logic [INTERP_BITS-1:0] interp_reg;
    logic                   reset_out_reg;

    // On even segments selector A sits on the upper node, so the
    // interpolator sees its inputs swapped and needs the inverted code.
    always_ff @(posedge clock) begin
        if (rst) begin
            latch_out_reg <= LATCH_RESET;
            sel_a_reg     <= 5'h00;
            sel_b_reg     <= 5'h00;
            interp_reg    <= 12'h000;
        end else begin
            latch_out_reg <= latch_reg;
            if (segment[0]) begin
                sel_a_reg  <= node_low;
                sel_b_reg  <= node_high;
                interp_reg <= fine;
            end else begin
                sel_a_reg  <= node_high;
                sel_b_reg  <= node_low;
                interp_reg <= ~fine;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reset_out_reg <= 1'b0;
        end else begin
            reset_out_reg <= supply_good;
        end
    end

    assign dac_latch               = latch_out_reg;
    assign segment_selector_a      = sel_a_reg;
    assign segment_selector_b      = sel_b_reg;
    assign interpolating_converter = interp_reg;
    assign amp_connect_gate        = state_reg[1];
    assign output_clamp_gate       = state_reg[0];
    assign track_hold              = hold_wire;
    assign reset_out_n             = reset_out_reg;

endmodule

`default_nettype wire

/* File: design/sdl_pkg.sv */
// Operation
// - Chain select low gives gated stand-alone frames.
// - Stand-alone shifts sixteen falling edges then blocks.
// - Full-resolution word is sent MSB first.
// - Reduced-resolution frame still sixteen bits, zero-padded.
// - Load input sampled after frame sync falls.
// - Low load input: update on sixteenth edge.
// - High load input: latch on its falling edge.
// - Output holds about five microseconds after strobe.
// - Automatic updates skip the hold interval.
// - Chain select high: ungated shifting, cascade enabled.
// - Bits beyond sixteen emerge on cascade output.
// - Cascade output advances on rising serial edge.
// - Frame sync high stops all further shifting.
// - Clear input loads zeros into converter latch.
// - Power-up clamps output until valid word loaded.
// - Reset input low clamps; reload releases it.
// - Supply detector state appears on reset output.
// - Upper four bits segment, lower twelve interpolate.
// - Interpolation code complemented on alternate segments.
// - Format select: binary low, two's complement high.
// - Frame sync fall reinitialises the bit counter.
`default_nettype none

package sdl_pkg;

    localparam int WORD_BITS   = 16;
    localparam int SEG_BITS    = 4;
    localparam int INTERP_BITS = 12;
    localparam int NODE_BITS   = 5;
    localparam int COUNT_BITS  = 5;

    localparam logic [COUNT_BITS-1:0] FRAME_BITS = 5'h10;
    localparam logic [COUNT_BITS-1:0] COUNT_RESET = 5'h00;
    localparam logic [WORD_BITS-1:0]  LATCH_RESET = 16'h0000;
    localparam logic [WORD_BITS-1:0]  LATCH_ZERO  = 16'h0000;

    localparam int CLK_PERIOD_NS = 8;
    localparam int HOLD_TIME_NS  = 5000;
    localparam int HOLD_CYCLES   = HOLD_TIME_NS / CLK_PERIOD_NS;
    localparam int HOLD_BITS     = 10;
    localparam logic [HOLD_BITS-1:0] HOLD_COUNT =
        HOLD_CYCLES[HOLD_BITS-1:0];
    localparam logic [HOLD_BITS-1:0] HOLD_RESET = 10'h000;

    typedef enum logic [1:0] {
        SDL_CLAMPED = 2'b01,
        SDL_LIVE    = 2'b10
    } sdl_out_state_t;

endpackage

`default_nettype wire

/* File: design/sdl_word_if.sv */
`default_nettype none

interface sdl_word_if;
    import sdl_pkg::*;

    logic [WORD_BITS-1:0] word;
    logic                 done_toggle;
    logic                 auto_mode;

    modport link (output word, output done_toggle, output auto_mode);
    modport core (input word, input done_toggle, input auto_mode);
endinterface

`default_nettype wire

/* File: design/sdl_serial_link.sv */
`default_nettype none

module sdl_serial_link
    import sdl_pkg::*;
(
    input  wire logic   rst,
    input  wire logic   serial_clk,
    input  wire logic   frame_sync_n,
    input  wire logic   serial_word_in,
    input  wire logic   chain_select,
    input  wire logic   latch_load_n,
    output var  logic   cascade_out,
    sdl_word_if.link    word_port
);

    logic [COUNT_BITS-1:0] count_reg;
    logic [WORD_BITS-1:0]  shift_reg;
    logic                  toggle_reg;
    logic                  auto_reg;
    logic                  cascade_reg;
    logic                  gate_open;

    // Counter is held clear while frame sync is high, so it restarts at
    // every falling edge of frame sync without needing a serial edge.
    assign gate_open = !frame_sync_n &&
                       (chain_select || count_reg != FRAME_BITS);

    ////////////////////////////////////////////////////////////////////////

    always_ff @(negedge serial_clk or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            count_reg <= COUNT_RESET;
        end else if (count_reg != FRAME_BITS) begin
            count_reg <= count_reg + 5'h01;
        end
    end

    always_ff @(negedge serial_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= LATCH_RESET;
        end else if (gate_open) begin
            shift_reg <= {shift_reg[WORD_BITS-2:0], serial_word_in};
        end
    end

    always_ff @(negedge serial_clk or posedge rst) begin
        if (rst) begin
            auto_reg   <= 1'b0;
            toggle_reg <= 1'b0;
        end else if (!frame_sync_n) begin
            if (count_reg == COUNT_RESET) begin
                auto_reg <= !latch_load_n;
            end
            if (count_reg == FRAME_BITS - 5'h01) begin
                toggle_reg <= !toggle_reg;
            end
        end
    end

    // Cascade data changes on the rising edge so the next device in the
    // chain samples a settled bit on the following falling edge.
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            cascade_reg <= 1'b0;
        end else if (chain_select && !frame_sync_n) begin
            cascade_reg <= shift_reg[WORD_BITS-1];
        end else if (!chain_select) begin
            cascade_reg <= 1'b0;
        end
    end

    assign cascade_out           = cascade_reg;
    assign word_port.word        = shift_reg;
    assign word_port.done_toggle = toggle_reg;
    assign word_port.auto_mode   = auto_reg;

endmodule

`default_nettype wire

/* File: design/sdl_hold_timer.sv */
`default_nettype none

module sdl_hold_timer
    import sdl_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic start,
    output var  logic hold
);

    logic [HOLD_BITS-1:0] count_reg;
    logic                 hold_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= HOLD_RESET;
            hold_reg  <= 1'b0;
        end else if (start) begin
            count_reg <= HOLD_COUNT - 10'h001;
            hold_reg  <= 1'b1;
        end else if (count_reg != HOLD_RESET) begin
            count_reg <= count_reg - 10'h001;
        end else begin
            hold_reg <= 1'b0;
        end
    end

    assign hold = hold_reg;

endmodule

`default_nettype wire

/* File: verification/sdl_load_control_monitor.sv */
`default_nettype none

module sdl_load_control_monitor
    import sdl_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   rst,
    input wire logic                   serial_clk,
    input wire logic                   chain_select,
    input wire logic                   latch_load_n,
    input wire logic                   latch_zero_n,
    input wire logic                   code_format_select,
    input wire logic                   reset_in_n,
    input wire logic                   supply_ok,
    input wire logic                   cascade_out,
    input wire logic                   reset_out_n,
    input wire logic [WORD_BITS-1:0]   dac_latch,
    input wire logic [NODE_BITS-1:0]   segment_selector_a,
    input wire logic [NODE_BITS-1:0]   segment_selector_b,
    input wire logic [INTERP_BITS-1:0] interpolating_converter,
    input wire logic                   amp_connect_gate,
    input wire logic                   output_clamp_gate,
    input wire logic                   track_hold
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic [HOLD_BITS-1:0] run_reg;
    logic [WORD_BITS-1:0] code;
    logic [NODE_BITS-1:0] low_node;

    // Counts how long the current hold interval has lasted.
    always_ff @(posedge clock) begin
        if (rst || !track_hold) begin
            run_reg <= HOLD_RESET;
        end else begin
            run_reg <= run_reg + 10'h001;
        end
    end

    assign code     = dac_latch ^ {code_format_select, 15'h0000};
    assign low_node = {1'b0, code[15:12]};

    ////////////////////////////////////////
    sequence s_strobe;
        $fell(latch_load_n) && latch_zero_n && !track_hold;
    endsequence
    sequence s_hold_on;
        ##[1:5] $rose(track_hold);
    endsequence
    property p_gates;
        amp_connect_gate != output_clamp_gate;
    endproperty
    property p_strobe;
        s_strobe |-> s_hold_on;
    endproperty
    property p_hold_len;
        $fell(track_hold) |-> run_reg == HOLD_COUNT;
    endproperty
    property p_auto_no_hold;
        !latch_load_n [*8] |-> !$rose(track_hold);
    endproperty
    property p_clear;
        !latch_zero_n [*6] |-> dac_latch == LATCH_ZERO;
    endproperty
    property p_reset_clamp;
        !reset_in_n [*5] |-> output_clamp_gate && !amp_connect_gate;
    endproperty
    property p_supply_up;
        supply_ok [*6] |-> reset_out_n;
    endproperty
    property p_supply_down;
        !supply_ok [*6] |-> !reset_out_n && output_clamp_gate;
    endproperty
    property p_split;
        ($stable(dac_latch) && $stable(code_format_select)) [*4] |->
            interpolating_converter == (code[12] ? code[11:0] : ~code[11:0])
            && segment_selector_a == low_node + {4'h0, !code[12]}
            && segment_selector_b == low_node + {4'h0, code[12]};
    endproperty
    property p_cascade;
        $changed(cascade_out) && $stable(chain_select) |-> $rose(serial_clk);
    endproperty

    a_gates: assert property (p_gates)
        else $error("Clamp and amplifier gates not exclusive.");
    a_strobe: assert property (p_strobe)
        else $error("Load strobe did not start the hold.");
    a_hold_len: assert property (p_hold_len)
        else $error("Hold interval has the wrong length.");
    a_auto_no_hold: assert property (p_auto_no_hold)
        else $error("Hold started while load input held low.");
    a_clear: assert property (p_clear)
        else $error("Clear did not zero the latch.");
    a_reset_clamp: assert property (p_reset_clamp)
        else $error("Reset input low did not clamp the output.");
    a_supply_up: assert property (p_supply_up)
        else $error("Reset output not high with good supply.");
    a_supply_down: assert property (p_supply_down)
        else $error("Supply loss not seen on reset output or clamp.");
    a_split: assert property (p_split)
        else $error("Segment split does not match latch code.");
    a_cascade: assert property (p_cascade)
        else $error("Cascade output moved without a rising serial edge.");
endmodule

bind sdl_load_control sdl_load_control_monitor u_sdl_load_control_monitor (.*);

`default_nettype wire

/* File: verification/sdl_host.sv */
`default_nettype none

module sdl_host (
    output var logic serial_clk,
    output var logic frame_sync_n,
    output var logic serial_word_in,
    input wire logic cascade_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] echo_reg;

    initial begin
        serial_clk = 1'b1;
        frame_sync_n = 1'b1;
        serial_word_in = 1'b0;
        echo_reg = 16'h0000;
    end

    ////////////////////////////////////////
    task automatic frame_begin();
        frame_sync_n = 1'b0;
        #62.5;
    endtask

    // The offset keeps serial edges off the system clock edges.
    task automatic shift16(input logic [15:0] w);
        #0.3;
        for (int i = 15; i >= 0; i--) begin
            serial_word_in = w[i];
            #62.5 serial_clk = 1'b0;
            echo_reg = {echo_reg[14:0], cascade_out};
            #62.5 serial_clk = 1'b1;
        end
    endtask

    // Released data shows the inverse of its last value.
    task automatic frame_end();
        #62.5 frame_sync_n = 1'b1;
        serial_word_in = ~serial_word_in;
    endtask
endmodule

`default_nettype wire

/* File: verification/sdl_load_control_bench.sv */
`default_nettype none

module sdl_load_control_bench import sdl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic                   clock, rst, serial_clk, frame_sync_n;
    logic                   serial_word_in, chain_select, latch_load_n;
    logic                   latch_zero_n, code_format_select, reset_in_n;
    logic                   supply_ok, cascade_out, reset_out_n;
    logic [WORD_BITS-1:0]   dac_latch;
    logic [NODE_BITS-1:0]   segment_selector_a, segment_selector_b;
    logic [INTERP_BITS-1:0] interpolating_converter;
    logic                   amp_connect_gate, output_clamp_gate, track_hold;
    logic [15:0]            words [4] = '{16'h1234, 16'h1FFF, 16'h3FFC,
                                          16'h8001};
    logic                   fmts [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    int                     n_errors = 0;
    int                     checked = 0;
    int                     cycles = 0;

    sdl_load_control u_sdl_load_control (.*);
    sdl_host u_sdl_host (.*);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    ////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic frame(input logic [15:0] w0, input logic [15:0] w1,
                         input int n);
        u_sdl_host.frame_begin();
        u_sdl_host.shift16(w0);
        if (n > 1) begin
            u_sdl_host.shift16(w1);
        end
        u_sdl_host.frame_end();
        wait_cyc(10);
    endtask

    task automatic strobe();
        latch_load_n = 1'b0;
        wait_cyc(4);
        latch_load_n = 1'b1;
        wait_cyc(4);
    endtask

    function automatic logic [15:0] exp_interp(input logic [15:0] w,
                                               input logic f);
        logic [15:0] c;
        c = w ^ {f, 15'h0000};
        return {4'h0, c[12] ? c[11:0] : ~c[11:0]};
    endfunction

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        chain_select = 1'b0;
        latch_load_n = 1'b1;
        latch_zero_n = 1'b1;
        code_format_select = 1'b0;
        reset_in_n = 1'b1;
        supply_ok = 1'b1;
        wait_cyc(16);
        rst = 1'b0;
        wait_cyc(8);
        check(16'(output_clamp_gate), 16'h0001);
        check(16'(reset_out_n), 16'h0001);
        frame(16'hA5C3, 16'hFFFF, 2);
        check(dac_latch, 16'h0000);
        strobe();
        check(dac_latch, 16'hA5C3);
        check(16'(track_hold), 16'h0001);
        check(16'(amp_connect_gate), 16'h0001);
        wait_cyc(700);
        check(16'(track_hold), 16'h0000);
        latch_load_n = 1'b0;
        wait_cyc(700);
        foreach (words[i]) begin
            code_format_select = fmts[i];
            frame(words[i], 16'h0000, 1);
            check(dac_latch, words[i]);
            check(16'(track_hold), 16'h0000);
            check({4'h0, interpolating_converter},
                  exp_interp(words[i], fmts[i]));
        end
        reset_in_n = 1'b0;
        wait_cyc(6);
        check(16'(output_clamp_gate), 16'h0001);
        reset_in_n = 1'b1;
        wait_cyc(6);
        check(16'(output_clamp_gate), 16'h0001);
        frame(16'h0F0F, 16'h0000, 1);
        check(16'(amp_connect_gate), 16'h0001);
        supply_ok = 1'b0;
        wait_cyc(8);
        check(16'(reset_out_n), 16'h0000);
        check(16'(output_clamp_gate), 16'h0001);
        supply_ok = 1'b1;
        frame(16'h7777, 16'h0000, 1);
        check(16'(amp_connect_gate), 16'h0001);
        latch_zero_n = 1'b0;
        wait_cyc(8);
        check(dac_latch, 16'h0000);
        latch_zero_n = 1'b1;
        latch_load_n = 1'b1;
        chain_select = 1'b1;
        wait_cyc(4);
        frame(16'hC0DE, 16'h5A0F, 2);
        check(u_sdl_host.echo_reg, 16'hC0DE);
        u_sdl_host.shift16(16'h1111);
        strobe();
        check(dac_latch, 16'h5A0F);
        wait_cyc(700);
        wrap_up();
    end
endmodule

`default_nettype wire
